//--- rtl/timer_b_map.vh
// Constants for the type-B timer: mode codes, clock selects, limits, timing
`ifndef TIMER_B_MAP_VH
`define TIMER_B_MAP_VH
// Timer modes
`define MODE_PERIODIC 3'h0
`define MODE_TIMEOUT 3'h1
`define MODE_CAPTURE_EVENT_EVT 3'h2
`define MODE_CAPTURE_EVENT_FRQ 3'h3
`define MODE_CAPTURE_EVENT_PW 3'h4
`define MODE_CAPTURE_EVENT_FPW 3'h5
`define MODE_SINGLE 3'h6
`define MODE_PWM8 3'h7
// Clock sources
`define CLK_SRC_PER 2'h0
`define CLK_SRC_PER2 2'h1
`define CLK_SRC_TYPE_A 2'h2
`define CLK_SRC_EVENT 2'h3
// Count limits
`define COUNT_FLOOR 16'h0000
`define COUNT_CEILING 16'hFFFF
`define COUNT_ONE 16'h0001
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
// Filter history patterns: all four samples high, all four low
`define FILTER_ALL_HIGH 4'hF
`define FILTER_ALL_LOW 4'h0
// Counter clock edges between an async set and the first increment
`define ASYNC_START_TICKS 2'h2
`endif

//--- rtl/timer_b.v
// Type-B timer: single-shot, 8-bit PWM, event capture, noise filter, type-A sync
//
// What this block does
// - Single-shot output stays low while the counter is stopped and no async start is pending.
// - Trigger edge clears count, counts up to compare value, output high meanwhile.
// - A readable running bit reports whether the single-shot counter counts.
// - At compare match stop, output low one counter tick, ignore triggers.
// - Synchronous trigger raises output three to four peripheral clocks after the event.
// - Edge select one starts on any edge, zero on rising edges only.
// - Enabling, edge-select change, or edge select one starts counting untriggered, unless the count is at 0xFFFF.
// - Async trigger select sets output on the same clock as a synchronous trigger.
// - Async start still begins incrementing two to three counter ticks later.
// - PWM counts zero to low byte, output set at zero, cleared at high byte.
// - PWM period is low byte plus one; high time is high byte.
// - Output enable drives waveform on the pin, otherwise nothing is driven.
// - Other modes take the initial output level from its control bit.
// - Cascade bit chain_two_counters is stored and read back but drives nothing.
// - Filter keeps four samples, passes a level only when all agree.
// - Filter samples on peripheral clock, adding four cycles of latency.
// - Type-A clock select counts on the type-A timer's chosen tick.
// - Restart-with-type-A restarts the counter when type-A restarts.
// - Floor 0x0000, full scale 0xFFFF; overflow raised on wrap to zero.
// - Capture and overflow events are one peripheral clock pulses.
`timescale 1ns/100ps
`default_nettype none
`include "timer_b_map.vh"

module timer_b
(
	input wire core_clk,
	input wire nrst,
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	input wire capture_event_evt_in,
	input wire count_evt_in,
	input wire type_a_clock,
	input wire type_a_restart,
	output reg capture_event,
	output reg overflow_event,
	output wire wave_out,
	output wire wave_oe
);

	// ------------------------------------------------------------
	// Register map (16-bit words)
	// ------------------------------------------------------------
	localparam [3:0] ADDR_CTRL_A = 4'h0;
	localparam [3:0] ADDR_CTRL_B = 4'h1;
	localparam [3:0] ADDR_EVENT_CONTROL_REG = 4'h2;
	localparam [3:0] ADDR_STATUS = 4'h3;
	localparam [3:0] ADDR_COUNT = 4'h4;
	localparam [3:0] ADDR_COMPARE_CAPTURE_VALUE = 4'h5;
	localparam [3:0] ADDR_FLAGS = 4'h6;

	// control_reg_a: [0] enable, [2:1] clock_source_select, [3] restart_with_type_a,
	// [4] chain_two_counters
	// control_reg_b: [2:0] timer_mode_select, [4] compare_output_enable,
	// [5] output_initial_level, [6] async_trigger_select
	// event_control_reg: [0] capture input enable, [4] edge select, [6] noise filter
	reg enable_q;
	reg [1:0] clk_sel_q;
	reg restart_a_q;
	reg chain_q;
	reg [2:0] mode_q;
	reg out_en_q;
	reg init_lvl_q;
	reg async_q;
	reg capture_event_ei_q;
	reg edge_q;
	reg filt_q;
	reg [15:0] count_q;
	reg [15:0] compare_capture_value_q;
	reg capture_event_flag_q;
	reg ovf_flag_q;
	reg run_q;
	reg wave_q;
	reg hold_low_q;
	reg [1:0] async_wait_q;
	reg async_hit_q;

	// ------------------------------------------------------------
	// Input synchronisers and noise filter
	// ------------------------------------------------------------
	reg capture_event_s1_q, capture_event_s2_q, cnt_s1_q, cnt_s2_q, tca_s1_q, tca_s2_q, rst_s1_q, rst_s2_q;
	reg [3:0] filt_hist_q;
	reg capture_event_lvl_q;
	reg cnt_prev_q;
	reg tca_prev_q;
	reg rst_prev_q;

	// Two flops on every pin-side input
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			capture_event_s1_q <= 1'b0;
			capture_event_s2_q <= 1'b0;
			cnt_s1_q <= 1'b0;
			cnt_s2_q <= 1'b0;
			tca_s1_q <= 1'b0;
			tca_s2_q <= 1'b0;
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			capture_event_s1_q <= capture_event_evt_in;
			capture_event_s2_q <= capture_event_s1_q;
			cnt_s1_q <= count_evt_in;
			cnt_s2_q <= cnt_s1_q;
			tca_s1_q <= type_a_clock;
			tca_s2_q <= tca_s1_q;
			rst_s1_q <= type_a_restart;
			rst_s2_q <= rst_s1_q;
		end
	end

	// Filtered level follows only four agreeing samples on core_clk
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			filt_hist_q <= `FILTER_ALL_LOW;
			capture_event_lvl_q <= 1'b0;
			cnt_prev_q <= 1'b0;
			tca_prev_q <= 1'b0;
			rst_prev_q <= 1'b0;
		end
		else
		begin
			filt_hist_q <= {filt_hist_q[2:0], capture_event_s2_q};
			if (!filt_q)
				capture_event_lvl_q <= capture_event_s2_q;
			else if (filt_hist_q == `FILTER_ALL_HIGH)
				capture_event_lvl_q <= 1'b1;
			else if (filt_hist_q == `FILTER_ALL_LOW)
				capture_event_lvl_q <= 1'b0;
			cnt_prev_q <= cnt_s2_q;
			tca_prev_q <= tca_s2_q;
			rst_prev_q <= rst_s2_q;
		end
	end

	// ------------------------------------------------------------
	// Edge detection and counter tick selection
	// ------------------------------------------------------------
	reg capture_event_lvl_prev_q;
	reg edge_q_prev_q;
	reg enable_prev_q;
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			capture_event_lvl_prev_q <= 1'b0;
			edge_q_prev_q <= 1'b0;
			enable_prev_q <= 1'b0;
		end
		else
		begin
			capture_event_lvl_prev_q <= capture_event_lvl_q;
			edge_q_prev_q <= edge_q;
			enable_prev_q <= enable_q;
		end
	end

	wire rise = capture_event_lvl_q & ~capture_event_lvl_prev_q;
	wire fall = ~capture_event_lvl_q & capture_event_lvl_prev_q;
	wire trig = capture_event_ei_q & (rise | (edge_q & fall));
	wire tca_tick = tca_s2_q & ~tca_prev_q;
	wire evt_tick = cnt_s2_q & ~cnt_prev_q;
	wire tca_restart = restart_a_q & rst_s2_q & ~rst_prev_q;
	reg tick;
	reg half_q;
	always @*
	begin
		tick = 1'b1;
		if (clk_sel_q == `CLK_SRC_PER2)
			tick = half_q;
		else if (clk_sel_q == `CLK_SRC_TYPE_A)
			tick = tca_tick;
		else if (clk_sel_q == `CLK_SRC_EVENT)
			tick = evt_tick;
	end

	// Untriggered start conditions in single-shot mode; a count at ceiling blocks all three
	wire auto_start = (count_q != `COUNT_CEILING) & ((enable_q & ~enable_prev_q)
		| (enable_q & (edge_q != edge_q_prev_q))
		| (enable_q & edge_q & ~run_q & ~hold_low_q));

	wire single = (mode_q == `MODE_SINGLE);
	wire pwm = (mode_q == `MODE_PWM8);
	wire at_ceiling = (count_q == `COUNT_CEILING);
	wire [7:0] cnt_lo = count_q[7:0];

	// ------------------------------------------------------------
	// Counter, waveform and events
	// ------------------------------------------------------------
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			count_q <= `COUNT_FLOOR;
			compare_capture_value_q <= `COUNT_FLOOR;
			run_q <= 1'b0;
			wave_q <= 1'b0;
			hold_low_q <= 1'b0;
			async_wait_q <= 2'h0;
			async_hit_q <= 1'b0;
			capture_event <= 1'b0;
			overflow_event <= 1'b0;
			capture_event_flag_q <= 1'b0;
			ovf_flag_q <= 1'b0;
		end
		else
		begin
			capture_event <= 1'b0;
			overflow_event <= 1'b0;
			if (reg_wr && reg_addr == ADDR_FLAGS)
			begin
				if (reg_wdata[0])
					capture_event_flag_q <= 1'b0;
				if (reg_wdata[1])
					ovf_flag_q <= 1'b0;
			end
			if (reg_wr && reg_addr == ADDR_COUNT)
				count_q <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_COMPARE_CAPTURE_VALUE)
				compare_capture_value_q <= reg_wdata;
			if (!enable_q)
			begin
				run_q <= 1'b0;
				hold_low_q <= 1'b0;
				async_wait_q <= 2'h0;
				if (single)
					wave_q <= 1'b0;
				else if (!pwm)
					wave_q <= init_lvl_q;
			end
			else if (tca_restart)
				count_q <= `COUNT_FLOOR;
			else if (single)
			begin
				if (hold_low_q)
				begin
					wave_q <= 1'b0;
					if (tick)
						hold_low_q <= 1'b0;
				end
				else if (async_wait_q != 2'h0)
				begin
					if (tick)
						async_wait_q <= async_wait_q - 2'h1;
					if (tick && async_wait_q == 2'h1)
						run_q <= 1'b1;
				end
				else if (!run_q && (trig || auto_start))
				begin
					count_q <= `COUNT_FLOOR;
					wave_q <= 1'b1;
					if (async_q && trig)
						async_wait_q <= `ASYNC_START_TICKS;
					else
						run_q <= 1'b1;
				end
				else if (run_q && tick)
				begin
					if (count_q == compare_capture_value_q)
					begin
						run_q <= 1'b0;
						wave_q <= 1'b0;
						hold_low_q <= 1'b1;
						capture_event <= 1'b1;
						capture_event_flag_q <= 1'b1;
					end
					else
						count_q <= count_q + `COUNT_ONE;
				end
				else if (!run_q)
					wave_q <= 1'b0;
			end
			else if (pwm)
			begin
				if (tick)
				begin
					if (cnt_lo == compare_capture_value_q[7:0])
					begin
						count_q <= `COUNT_FLOOR;
						wave_q <= (compare_capture_value_q[15:8] != `BYTE_ZERO);
						capture_event <= 1'b1;
						capture_event_flag_q <= 1'b1;
					end
					else
					begin
						count_q <= {8'h00, cnt_lo + `BYTE_ONE};
						if (cnt_lo + `BYTE_ONE == compare_capture_value_q[15:8])
							wave_q <= 1'b0;
					end
				end
			end
			else
			begin
				if (tick)
				begin
					count_q <= count_q + `COUNT_ONE;
					if (at_ceiling)
					begin
						overflow_event <= 1'b1;
						ovf_flag_q <= 1'b1;
					end
				end
				if (mode_q == `MODE_CAPTURE_EVENT_EVT && trig)
				begin
					compare_capture_value_q <= count_q;
					capture_event <= 1'b1;
					capture_event_flag_q <= 1'b1;
				end
			end
		end
	end

	// Pin drive only with output enable set
	assign wave_out = out_en_q & wave_q;
	assign wave_oe = out_en_q;

	// ------------------------------------------------------------
	// Register writes and reads
	// ------------------------------------------------------------
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			enable_q <= 1'b0;
			clk_sel_q <= `CLK_SRC_PER;
			restart_a_q <= 1'b0;
			chain_q <= 1'b0;
			mode_q <= `MODE_PERIODIC;
			out_en_q <= 1'b0;
			init_lvl_q <= 1'b0;
			async_q <= 1'b0;
			capture_event_ei_q <= 1'b0;
			edge_q <= 1'b0;
			filt_q <= 1'b0;
			half_q <= 1'b0;
			reg_rdata <= 16'h0000;
		end
		else
		begin
			half_q <= ~half_q;
			if (reg_wr && reg_addr == ADDR_CTRL_A)
			begin
				enable_q <= reg_wdata[0];
				clk_sel_q <= reg_wdata[2:1];
				restart_a_q <= reg_wdata[3];
				chain_q <= reg_wdata[4];
			end
			if (reg_wr && reg_addr == ADDR_CTRL_B)
			begin
				mode_q <= reg_wdata[2:0];
				out_en_q <= reg_wdata[4];
				init_lvl_q <= reg_wdata[5];
				async_q <= reg_wdata[6];
			end
			if (reg_wr && reg_addr == ADDR_EVENT_CONTROL_REG)
			begin
				capture_event_ei_q <= reg_wdata[0];
				edge_q <= reg_wdata[4];
				filt_q <= reg_wdata[6];
			end
			reg_rdata <= 16'h0000;
			if (reg_rd)
			begin
				if (reg_addr == ADDR_CTRL_A)
					reg_rdata <= {11'h000, chain_q, restart_a_q, clk_sel_q, enable_q};
				else if (reg_addr == ADDR_CTRL_B)
					reg_rdata <= {9'h000, async_q, init_lvl_q, out_en_q, 1'b0, mode_q};
				else if (reg_addr == ADDR_EVENT_CONTROL_REG)
					reg_rdata <= {9'h000, filt_q, 1'b0, edge_q, 3'h0, capture_event_ei_q};
				else if (reg_addr == ADDR_STATUS)
					reg_rdata <= {15'h0000, run_q};
				else if (reg_addr == ADDR_COUNT)
					reg_rdata <= count_q;
				else if (reg_addr == ADDR_COMPARE_CAPTURE_VALUE)
					reg_rdata <= compare_capture_value_q;
				else if (reg_addr == ADDR_FLAGS)
					reg_rdata <= {14'h0000, ovf_flag_q, capture_event_flag_q};
			end
		end
	end

endmodule // timer_b
`default_nettype wire

//--- sim/timer_b_asserts.sv
// Port checks for the type-B timer
`timescale 1ns/100ps
`default_nettype none
`include "timer_b_map.vh"
module timer_b_asserts (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic capture_event_evt_in,
	input wire logic count_evt_in,
	input wire logic type_a_clock,
	input wire logic type_a_restart,
	input wire logic capture_event,
	input wire logic overflow_event,
	input wire logic wave_out,
	input wire logic wave_oe
);
logic [2:0] mode_q;
default clocking @(posedge core_clk); endclocking
default disable iff (!nrst);
// Mode as last written by software
always @(posedge core_clk or negedge nrst)
	if (!nrst)
		mode_q <= 3'h0;
	else if (reg_wr && reg_addr == 4'h1)
		mode_q <= reg_wdata[2:0];
a_oe_gate: assert property (!wave_oe |-> !wave_out)
	else $error("wave_out without enable");
a_oe_follow: assert property (reg_wr && reg_addr == 4'h1 |=> wave_oe == $past(reg_wdata[4]))
	else $error("wave_oe not from write");
a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
	else $error("read data outside slot");
a_run_bit: assert property (reg_rd && reg_addr == 4'h3 |=> reg_rdata[15:1] == 15'h0000)
	else $error("status beyond run bit");
a_capture_event_pulse: assert property (capture_event |=> !capture_event)
	else $error("capture pulse too long");
a_ovf_pulse: assert property (overflow_event |=> !overflow_event)
	else $error("overflow pulse too long");
a_no_ovf_ss: assert property (mode_q[2:1] == 2'b11 |=> !overflow_event)
	else $error("overflow in shot or pwm");
a_ss_stop_low: assert property (mode_q == `MODE_SINGLE && capture_event |-> ##[0:1] !wave_out)
	else $error("shot output high at match");
c_pwm: cover property (mode_q == `MODE_PWM8 && capture_event);
c_shot: cover property (mode_q == `MODE_SINGLE && $fell(wave_out));
c_wrap: cover property (overflow_event);
endmodule // timer_b_asserts
bind timer_b timer_b_asserts i_chk (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.capture_event_evt_in(capture_event_evt_in), .count_evt_in(count_evt_in), .type_a_clock(type_a_clock),
	.type_a_restart(type_a_restart), .capture_event(capture_event),
	.overflow_event(overflow_event), .wave_out(wave_out), .wave_oe(wave_oe));
`default_nettype wire

//--- sim/evt_net.sv
// Event routing and type-A timer stand-in
`timescale 1ns/100ps
`default_nettype none
module evt_net (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [3:0] req,
	input wire logic [7:0] len,
	input wire logic ta_run,
	output logic [3:0] lines
);
int left [4];
int k;
logic [1:0] div_q;
// Lines 0,1,3 pulse for len cycles; line 2 is the type-A tick
always @(posedge core_clk or negedge nrst)
begin
	if (!nrst)
	begin
		lines <= 4'h0;
		div_q <= 2'h0;
	end
	else
	begin
		div_q <= div_q + 2'h1;
		for (k = 0; k < 4; k++)
		begin
			if (k == 2)
				lines[k] <= ta_run & div_q[1];
			else if (req[k])
			begin
				lines[k] <= 1'b1;
				left[k] <= len;
			end
			else if (left[k] > 1)
				left[k] <= left[k] - 1;
			else
				lines[k] <= 1'b0;
		end
	end
end
endmodule // evt_net
`default_nettype wire

//--- sim/test_timer_b.sv
// Self-checking bench for the type-B timer
`timescale 1ns/100ps
`default_nettype none
module test_timer_b;
logic core_clk, nrst, reg_wr, reg_rd, ta_run;
logic [3:0] reg_addr, req;
logic [15:0] reg_wdata, d, e;
logic [7:0] len;
wire logic [15:0] reg_rdata;
wire logic [3:0] lines;
wire logic capture_event, overflow_event, wave_out, wave_oe;
wire logic [1:0] obs = {capture_event, wave_out};
int failures, n_compared, n, p, hi, lo;
int unsigned rng;
timer_b i_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.capture_event_evt_in(lines[0]), .count_evt_in(lines[1]), .type_a_clock(lines[2]),
	.type_a_restart(lines[3]), .capture_event(capture_event),
	.overflow_event(overflow_event), .wave_out(wave_out), .wave_oe(wave_oe));
evt_net i_net (.core_clk(core_clk), .nrst(nrst), .req(req), .len(len),
	.ta_run(ta_run), .lines(lines));
// Clock
initial
begin
	core_clk = 1'b0;
	forever #5 core_clk = ~core_clk;
end
function automatic int unsigned xs();
	rng ^= rng << 13;
	rng ^= rng >> 17;
	rng ^= rng << 5;
	return rng;
endfunction
task automatic chkr(input string s, input logic [15:0] a, b, g);
	n_compared++;
	if ((g >= a && g <= b) !== 1'b1)
	begin
		failures++;
		$display("[ERR] %s exp %0d..%0d got %0d", s, a, b, g);
	end
endtask
task automatic wr(input logic [3:0] a, input logic [15:0] v);
	reg_wr <= 1'b1;
	reg_addr <= a;
	reg_wdata <= v;
	@(posedge core_clk);
	reg_wr <= 1'b0;
	@(posedge core_clk);
endtask
task automatic rd(input logic [3:0] a, output logic [15:0] v);
	reg_rd <= 1'b1;
	reg_addr <= a;
	@(posedge core_clk);
	reg_rd <= 1'b0;
	@(posedge core_clk);
	v = reg_rdata;
endtask
task automatic waitw(input int s, input logic v, input int b, output int c);
	c = 0;
	while (obs[s] !== v && c < b)
	begin
		@(posedge core_clk);
		c++;
	end
endtask
task automatic trig(input int k, input logic [7:0] l);
	req <= 4'h1 << k;
	len <= l;
	@(posedge core_clk);
	req <= 4'h0;
endtask
// One whole period between capture pulses, with its high cycles
task automatic meas(output int c, output int h);
	waitw(1, 1'b1, 600, c);
	c = 0;
	h = 0;
	do
	begin
		@(posedge core_clk);
		c++;
		h += (wave_out === 1'b1);
	end
	while (capture_event !== 1'b1 && c < 600);
endtask
task automatic close_out();
	$display("compared %0d, failures %0d", n_compared, failures);
	if (failures == 0 && n_compared > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
// Watchdog
initial
begin
	#300000;
	failures++;
	close_out();
end
// -----
// Main sequence
// -----
initial
begin
	{nrst, reg_wr, reg_rd, ta_run} = 4'h0;
	reg_addr = 4'h0;
	reg_wdata = 16'h0000;
	req = 4'h0;
	len = 8'h01;
	rng = 98;
	repeat (3) @(posedge core_clk);
	nrst <= 1'b1;
	@(posedge core_clk);
	chkr("wave_oe", 0, 0, 16'(wave_oe));
	for (int k = 0; k < 3; k++)
	begin
		lo = 4 + xs() % 16;
		hi = 1 + xs() % lo;
		wr(4'h4, 16'h0000);
		wr(4'h5, {hi[7:0], lo[7:0]});
		wr(4'h1, 16'h0017);
		wr(4'h0, 16'h0001);
		meas(p, n);
		chkr("pwm period", lo + 1, lo + 1, p[15:0]);
		chkr("pwm high", hi, hi, n[15:0]);
		wr(4'h0, 16'h0000);
	end
	wr(4'h5, 16'h0006);
	wr(4'h2, 16'h0001);
	wr(4'h4, 16'h0000);
	wr(4'h1, 16'h0016);
	wr(4'h0, 16'h0001);
	waitw(0, 1'b1, 10, n);
	chkr("auto start", 0, 9, n[15:0]);
	rd(4'h3, d);
	chkr("run busy", 1, 1, d);
	waitw(0, 1'b0, 20, n);
	rd(4'h3, d);
	chkr("run idle", 0, 0, d);
	for (int a = 0; a < 2; a++)
	begin
		wr(4'h0, 16'h0000);
		wr(4'h4, 16'hFFFF);
		wr(4'h1, a ? 16'h0056 : 16'h0016);
		wr(4'h0, 16'h0001);
		waitw(0, 1'b1, 12, n);
		chkr("held low", 12, 12, n[15:0]);
		trig(0, 8'h1E);
		waitw(0, 1'b1, 10, n);
		chkr("trig delay", 1, 8, n[15:0]);
		waitw(0, 1'b0, 20, n);
		chkr("width", 6, 10, n[15:0]);
		waitw(0, 1'b1, 40, n);
		chkr("fall edge", 40, 40, n[15:0]);
	end
	wr(4'h0, 16'h0000);
	wr(4'h2, 16'h0041);
	wr(4'h1, 16'h0002);
	wr(4'h4, 16'hFFF0);
	wr(4'h0, 16'h0001);
	n = 0;
	while (overflow_event !== 1'b1 && n < 40)
	begin
		@(posedge core_clk);
		n++;
	end
	chkr("wrap", 10, 18, n[15:0]);
	rd(4'h6, d);
	chkr("ovf flag", 2, 2, d & 16'h0002);
	wr(4'h6, 16'h0003);
	trig(0, 8'h02);
	waitw(1, 1'b1, 16, n);
	chkr("glitch", 16, 16, n[15:0]);
	trig(0, 8'h08);
	waitw(1, 1'b1, 16, n);
	chkr("filter lag", 4, 12, n[15:0]);
	rd(4'h5, d);
	rd(4'h4, e);
	chkr("capture", 2, 12, e - d);
	wr(4'h0, 16'h0005);
	ta_run <= 1'b1;
	rd(4'h4, d);
	repeat (40) @(posedge core_clk);
	rd(4'h4, e);
	chkr("ta ticks", 9, 12, e - d);
	wr(4'h0, 16'h000D);
	trig(3, 8'h02);
	repeat (6) @(posedge core_clk);
	rd(4'h4, d);
	chkr("restart", 0, 3, d);
	close_out();
end
endmodule // test_timer_b
`default_nettype wire
